/* rtl/ued_consts.vh */
// Constants for the endpoint descriptor engine: record layout, bit positions and codes.
`ifndef UED_CONSTS_VH
`define UED_CONSTS_VH

// ================================
// Record byte offsets
`define UED_OFS_STATUS 3'h0
`define UED_OFS_CTRL 3'h1
`define UED_OFS_CNT_LO 3'h2
`define UED_OFS_CNT_HI 3'h3
`define UED_OFS_PTR_LO 3'h4
`define UED_OFS_PTR_HI 3'h5
`define UED_OFS_AUX_LO 3'h6
`define UED_OFS_AUX_HI 3'h7
`define UED_OFS_LAST 3'h7
`define UED_EP_STRIDE_SHIFT 4
`define UED_IN_OFFSET 16'h0008
`define UED_WR_BASIC 8'h01
`define UED_WR_IN_MULTI 8'hC1
`define UED_WR_OUT 8'h0D

// ================================
// Status byte bit positions
`define UED_ST_STALL 7
`define UED_ST_NOTREADY 6
`define UED_ST_DONE_A 5
`define UED_ST_DONE_B 4
`define UED_ST_BANK 3
`define UED_ST_REFUSE1 2
`define UED_ST_REFUSE0 1
`define UED_ST_TOGGLE 0

// ================================
// Control byte fields
`define UED_CT_TYPE_HI 7
`define UED_CT_TYPE_LO 6
`define UED_CT_MULTI 5
`define UED_CT_DBUF 4
`define UED_CT_IRQMASK 3
`define UED_CT_STALL 2
`define UED_TYPE_DISABLED 2'h0
`define UED_TYPE_CONTROL 2'h1
`define UED_TYPE_BULK 2'h2
`define UED_TYPE_ISO 2'h3

// ================================
// Count high byte fields
`define UED_CH_AUTO_ZERO_LENGTH 7

// ================================
// Token kinds and answer codes
`define UED_TOK_OUT 2'h0
`define UED_TOK_IN 2'h1
`define UED_TOK_SETUP 2'h2
`define UED_ANS_ACK 2'h0
`define UED_ANS_NAK 2'h1
`define UED_ANS_STALL 2'h2
`define UED_ANS_SILENT 2'h3

`endif

/* rtl/ued_rec_addr.v */
// Record byte address generator for the endpoint descriptor engine.
`timescale 1ns/1ps
`include "ued_consts.vh"
module ued_rec_addr (
	// Table location and selection
	input wire [15:0] table_base,
	input wire [3:0] ep_addr,
	input wire dir_in,
	input wire [2:0] byte_idx,
	// Result
	output wire [15:0] byte_addr
);
	// Output records sit at base plus 16 per address, input records 8 bytes further.
	assign byte_addr = table_base + ({12'h000, ep_addr} << `UED_EP_STRIDE_SHIFT)
		+ (dir_in ? `UED_IN_OFFSET : 16'h0000) + {13'h0000, byte_idx};
endmodule

/* rtl/ued_payload_decode.v */
// Maximum payload decoder for the endpoint buffer size field.
`timescale 1ns/1ps
module ued_payload_decode #(
	parameter SIZE_W = 11
) (
	// Field and type
	input wire [2:0] size_code,
	input wire is_iso,
	// Decoded size in bytes
	output reg [SIZE_W-1:0] max_bytes
);
	reg [2:0] code;

	// Non-isochronous endpoints only see the two low code bits.
	always @* begin
		code = is_iso ? size_code : {1'b0, size_code[1:0]};
		case (code)
			3'h0: max_bytes = 11'h008;
			3'h1: max_bytes = 11'h010;
			3'h2: max_bytes = 11'h020;
			3'h3: max_bytes = 11'h040;
			3'h4: max_bytes = 11'h080;
			3'h5: max_bytes = 11'h100;
			3'h6: max_bytes = 11'h200;
			default: max_bytes = 11'h3FF;
		endcase
	end
endmodule

/* rtl/ued_engine.v */
// Endpoint descriptor engine: fetches, answers from and updates endpoint records in SRAM.
// How it works
// - Sixteen addresses, each with IN and OUT record.
// - Record at base plus 16 per address, IN plus 8.
// - STALL answer sets status bit 7; W1C.
// - Isochronous OUT CRC error sets bit 7.
// - Not-ready IN or OUT sets status bit 6.
// - Successful IN or OUT sets status bit 5.
// - Successful SETUP, IN or OUT sets bit 4.
// - Bit 3 selects bank, toggles per success.
// - Refuse flags discard data, NAK unless isochronous.
// - Bit 0 is data toggle; isochronous ignores it.
// - Type field: disabled, control, bulk, isochronous.
// - Disabled endpoint: only control byte touched.
// - Multipacket moves large payloads with one interrupt at the end.
// - Ping-pong: bank bit picks refuse flag 1 or 0.
// - Interrupt mask: flags only, no completion push.
// - Size codes give 8 to 1023 bytes.
// - Ten-bit byte count per endpoint.
// - Auto zero-length packet for multipacket IN endpoints.
// - Data buffer address from bytes 4 and 5.
// - IN multipacket accumulates sent bytes in aux.
// - Table base from two separate byte registers.
`timescale 1ns/1ps
`include "ued_consts.vh"
module ued_engine #(
	parameter SIZE_W = 11
) (
	// Clock, reset, enable
	input wire mclk,
	input wire arst_n,
	input wire ce,
	// Table base byte registers
	input wire base_lo_we,
	input wire base_hi_we,
	input wire [7:0] base_wdata,
	output reg [15:0] table_base_q,
	// Transaction request from the link logic
	input wire txn_req,
	input wire [3:0] txn_ep,
	input wire [1:0] txn_tok,
	output reg txn_ready_q,
	// Answer to the link logic
	output reg ans_valid_q,
	output reg [1:0] ans_code_q,
	output reg ans_toggle_q,
	output reg [15:0] ans_ptr_q,
	output reg [9:0] ans_len_q,
	output reg [SIZE_W-1:0] ans_max_q,
	// Transaction outcome from the link logic
	input wire done_valid,
	input wire done_ok,
	input wire done_crc_err,
	input wire [9:0] done_count,
	// SRAM byte port
	output reg mem_req_q,
	output reg mem_we_q,
	output reg [15:0] mem_addr_q,
	output reg [7:0] mem_wdata_q,
	input wire mem_ack,
	input wire [7:0] mem_rdata,
	// Completion queue push
	output reg cmpl_push_q,
	output reg [15:0] cmpl_addr_q
);
	// ================================
	// State machine
	localparam S_IDLE = 3'h0;
	localparam S_RD_CTRL = 3'h1;
	localparam S_RD_REST = 3'h2;
	localparam S_ANSWER = 3'h3;
	localparam S_WAIT = 3'h4;
	localparam S_RD_STAT = 3'h5;
	localparam S_WRITE = 3'h6;

	reg [2:0] state_q;
	reg [2:0] idx_q;
	reg [3:0] ep_q;
	reg [1:0] tok_q;
	reg [7:0] rec_q [0:7];
	reg [7:0] set_mask_q;
	reg [7:0] flip_mask_q;
	reg [7:0] wr_mask_q;
	reg push_pend_q;
	reg [1:0] code_q;
	wire [15:0] byte_addr;
	wire [SIZE_W-1:0] max_bytes;

	// ================================
	// Record field views
	wire dir_in = (tok_q == `UED_TOK_IN);
	wire [7:0] st = rec_q[`UED_OFS_STATUS];
	wire [7:0] ctrl = rec_q[`UED_OFS_CTRL];
	wire [1:0] ep_type = ctrl[`UED_CT_TYPE_HI:`UED_CT_TYPE_LO];
	wire is_iso = (ep_type == `UED_TYPE_ISO);
	wire multi = ctrl[`UED_CT_MULTI];
	wire dbuf = ctrl[`UED_CT_DBUF] && (ep_type != `UED_TYPE_CONTROL);
	wire stall_en = ctrl[`UED_CT_STALL] && !is_iso && (tok_q != `UED_TOK_SETUP);
	wire [9:0] cnt = {rec_q[`UED_OFS_CNT_HI][1:0], rec_q[`UED_OFS_CNT_LO]};
	wire auto_zero_length = rec_q[`UED_OFS_CNT_HI][`UED_CH_AUTO_ZERO_LENGTH];
	wire [15:0] ptr = {rec_q[`UED_OFS_PTR_HI], rec_q[`UED_OFS_PTR_LO]};
	wire [15:0] aux = {rec_q[`UED_OFS_AUX_HI], rec_q[`UED_OFS_AUX_LO]};
	// In ping-pong the bank bit picks the buffer; otherwise buffer 0 always serves.
	wire bank = dbuf && st[`UED_ST_BANK];
	wire refuse = bank ? st[`UED_ST_REFUSE1] : st[`UED_ST_REFUSE0];
	wire [9:0] remain = (aux >= {6'h00, cnt}) ? 10'h000 : (cnt - aux[9:0]);
	wire [9:0] want = (multi && dir_in) ? remain : cnt;
	wire [9:0] max10 = max_bytes[9:0];
	wire [9:0] in_len = (want > max10) ? max10 : want;
	wire [9:0] rx_len = (done_count > max10) ? max10 : done_count;
	wire [15:0] moved = dir_in ? aux : {6'h00, cnt};
	wire [9:0] out_cnt = (multi && !dir_in) ? (cnt + rx_len) : rx_len;
	wire [15:0] in_aux = aux + {6'h00, ans_len_q};
	// A full-size last IN packet with auto zero-length still owes a ZLP.
	wire in_final = (in_aux >= {6'h00, cnt}) && !(auto_zero_length && (ans_len_q == max10));
	wire out_final = ({6'h00, out_cnt} >= aux) || (rx_len < max10);
	wire is_final = !multi || (tok_q == `UED_TOK_SETUP) || (dir_in ? in_final : out_final);

	ued_rec_addr u_addr (
		.table_base(table_base_q),
		.ep_addr(ep_q),
		.dir_in(dir_in),
		.byte_idx(idx_q),
		.byte_addr(byte_addr)
	);

	ued_payload_decode #(
		.SIZE_W(SIZE_W)
	) u_size (
		.size_code(ctrl[2:0]),
		.is_iso(is_iso),
		.max_bytes(max_bytes)
	);

	// ================================
	// Table base registers
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			table_base_q <= 16'h0000;
		end else if (ce) begin
			if (base_lo_we) begin
				table_base_q[7:0] <= base_wdata;
			end
			if (base_hi_we) begin
				table_base_q[15:8] <= base_wdata;
			end
		end
	end

	// ================================
	// Record storage
	genvar gi;
	generate
		for (gi = 0; gi <= `UED_OFS_LAST; gi = gi + 1) begin : g_rec
			always @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					rec_q[gi] <= 8'h00;
				end else if (ce) begin
					if (mem_req_q && !mem_we_q && mem_ack && idx_q == gi) begin
						// A fresh status read merges hardware events on top of software clears.
						if (state_q == S_RD_STAT) begin
							rec_q[gi] <= (mem_rdata | set_mask_q) ^ flip_mask_q;
						end else begin
							rec_q[gi] <= mem_rdata;
						end
					end else if (state_q == S_WAIT && done_valid && done_ok) begin
						if (!dir_in && gi == `UED_OFS_CNT_LO) begin
							rec_q[gi] <= out_cnt[7:0];
						end else if (!dir_in && gi == `UED_OFS_CNT_HI) begin
							rec_q[gi] <= {auto_zero_length, 5'h00, out_cnt[9:8]};
						end else if (dir_in && multi && gi == `UED_OFS_AUX_LO) begin
							rec_q[gi] <= in_aux[7:0];
						end else if (dir_in && multi && gi == `UED_OFS_AUX_HI) begin
							rec_q[gi] <= in_aux[15:8];
						end
					end
				end
			end
		end
	endgenerate

	// ================================
	// Sequencer
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= S_IDLE;
			idx_q <= 3'h0;
			ep_q <= 4'h0;
			tok_q <= 2'h0;
			txn_ready_q <= 1'b0;
			ans_valid_q <= 1'b0;
			ans_code_q <= 2'h0;
			ans_toggle_q <= 1'b0;
			ans_ptr_q <= 16'h0000;
			ans_len_q <= 10'h000;
			ans_max_q <= {SIZE_W{1'b0}};
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_addr_q <= 16'h0000;
			mem_wdata_q <= 8'h00;
			cmpl_push_q <= 1'b0;
			cmpl_addr_q <= 16'h0000;
			set_mask_q <= 8'h00;
			flip_mask_q <= 8'h00;
			wr_mask_q <= 8'h00;
			push_pend_q <= 1'b0;
			code_q <= 2'h0;
		end else if (ce) begin
			ans_valid_q <= 1'b0;
			cmpl_push_q <= 1'b0;
			case (state_q)
				S_IDLE: begin
					txn_ready_q <= 1'b1;
					if (txn_req && txn_ready_q) begin
						txn_ready_q <= 1'b0;
						ep_q <= txn_ep;
						tok_q <= txn_tok;
						idx_q <= `UED_OFS_CTRL;
						set_mask_q <= 8'h00;
						flip_mask_q <= 8'h00;
						wr_mask_q <= `UED_WR_BASIC;
						push_pend_q <= 1'b0;
						state_q <= S_RD_CTRL;
					end
				end
				S_RD_CTRL: begin
					if (!mem_req_q) begin
						mem_req_q <= 1'b1;
						mem_we_q <= 1'b0;
						mem_addr_q <= byte_addr;
					end else if (mem_ack) begin
						mem_req_q <= 1'b0;
						if (mem_rdata[`UED_CT_TYPE_HI:`UED_CT_TYPE_LO] == `UED_TYPE_DISABLED) begin
							// Nothing else in the record is touched.
							state_q <= S_IDLE;
						end else begin
							idx_q <= `UED_OFS_STATUS;
							state_q <= S_RD_REST;
						end
					end
				end
				S_RD_REST: begin
					if (!mem_req_q) begin
						mem_req_q <= 1'b1;
						mem_we_q <= 1'b0;
						mem_addr_q <= byte_addr;
					end else if (mem_ack) begin
						mem_req_q <= 1'b0;
						if (idx_q == `UED_OFS_LAST) begin
							state_q <= S_ANSWER;
						end else if (idx_q == `UED_OFS_STATUS) begin
							idx_q <= `UED_OFS_CNT_LO;
						end else begin
							idx_q <= idx_q + 3'h1;
						end
					end
				end
				S_ANSWER: begin
					ans_valid_q <= 1'b1;
					ans_toggle_q <= is_iso ? 1'b0 : st[`UED_ST_TOGGLE];
					ans_ptr_q <= multi ? (ptr + moved) : ptr;
					ans_len_q <= in_len;
					ans_max_q <= max_bytes;
					if (stall_en) begin
						ans_code_q <= `UED_ANS_STALL;
						code_q <= `UED_ANS_STALL;
						set_mask_q[`UED_ST_STALL] <= 1'b1;
						state_q <= S_RD_STAT;
					end else if (refuse) begin
						// Data to a refused buffer is dropped; isochronous has no handshake.
						ans_code_q <= is_iso ? `UED_ANS_SILENT : `UED_ANS_NAK;
						code_q <= is_iso ? `UED_ANS_SILENT : `UED_ANS_NAK;
						set_mask_q[`UED_ST_NOTREADY] <= 1'b1;
						state_q <= S_RD_STAT;
					end else begin
						ans_code_q <= `UED_ANS_ACK;
						code_q <= `UED_ANS_ACK;
						state_q <= S_WAIT;
					end
					idx_q <= `UED_OFS_STATUS;
				end
				S_WAIT: begin
					if (done_valid) begin
						state_q <= S_RD_STAT;
						if (done_ok) begin
							flip_mask_q[`UED_ST_TOGGLE] <= !is_iso;
							flip_mask_q[`UED_ST_BANK] <= dbuf;
							if (dir_in) begin
								wr_mask_q <= multi ? `UED_WR_IN_MULTI : `UED_WR_BASIC;
							end else begin
								wr_mask_q <= `UED_WR_OUT;
							end
							// Multipacket raises flags only when the whole payload has moved.
							if (is_final) begin
								set_mask_q[`UED_ST_DONE_A] <= (tok_q != `UED_TOK_SETUP);
								set_mask_q[`UED_ST_DONE_B] <= 1'b1;
								set_mask_q[`UED_ST_REFUSE1] <= bank;
								set_mask_q[`UED_ST_REFUSE0] <= !bank;
								push_pend_q <= !ctrl[`UED_CT_IRQMASK];
							end
						end else if (done_crc_err && is_iso && !dir_in) begin
							set_mask_q[`UED_ST_STALL] <= 1'b1;
						end
					end
				end
				S_RD_STAT: begin
					if (!mem_req_q) begin
						mem_req_q <= 1'b1;
						mem_we_q <= 1'b0;
						mem_addr_q <= byte_addr;
					end else if (mem_ack) begin
						mem_req_q <= 1'b0;
						state_q <= S_WRITE;
					end
				end
				S_WRITE: begin
					if (!mem_req_q) begin
						if (wr_mask_q[idx_q]) begin
							mem_req_q <= 1'b1;
							mem_we_q <= 1'b1;
							mem_addr_q <= byte_addr;
							mem_wdata_q <= rec_q[idx_q];
						end else if (idx_q == `UED_OFS_LAST) begin
							state_q <= S_IDLE;
						end else begin
							idx_q <= idx_q + 3'h1;
						end
					end else if (mem_ack) begin
						mem_req_q <= 1'b0;
						mem_we_q <= 1'b0;
						if (idx_q == `UED_OFS_LAST) begin
							state_q <= S_IDLE;
						end else begin
							idx_q <= idx_q + 3'h1;
						end
					end
					if (state_q == S_WRITE && !mem_req_q && idx_q == `UED_OFS_LAST
						&& !wr_mask_q[idx_q] && push_pend_q) begin
						cmpl_push_q <= 1'b1;
						cmpl_addr_q <= byte_addr - {13'h0000, `UED_OFS_LAST};
					end
					if (mem_req_q && mem_ack && idx_q == `UED_OFS_LAST && push_pend_q) begin
						cmpl_push_q <= 1'b1;
						cmpl_addr_q <= mem_addr_q - {13'h0000, `UED_OFS_LAST};
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end
endmodule

/* test/ued_sram_model.sv */
// Byte SRAM model answering the engine memory port after one to four cycles.
`timescale 1ns/1ps
module ued_sram_model (
	// Engine memory port
	input wire mclk,
	input wire mem_req_q,
	input wire mem_we_q,
	input wire [15:0] mem_addr_q,
	input wire [7:0] mem_wdata_q,
	output logic mem_ack,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];
	logic [1:0] dly_q;
	logic [1:0] lat_q;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 8'h00;
		dly_q = 2'h0;
		lat_q = 2'h0;
	end
	// Read data flips every idle cycle so a stale byte never looks fresh.
	always @(posedge mclk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req_q && !mem_ack) begin
			dly_q <= dly_q + 2'h1;
			if (dly_q == lat_q) begin
				mem_ack <= 1'b1;
				dly_q <= 2'h0;
				lat_q <= lat_q + 2'h3;
				if (mem_we_q) begin
					mem[mem_addr_q] <= mem_wdata_q;
				end else begin
					mem_rdata <= mem[mem_addr_q];
				end
			end
		end
	end
endmodule

/* test/ued_engine_monitor.sv */
// Checker watching the endpoint descriptor engine ports.
`timescale 1ns/1ps
module ued_engine_monitor #(
	parameter SIZE_W = 11
) (
	// Engine ports
	input wire mclk,
	input wire arst_n,
	input wire ce,
	input wire base_lo_we,
	input wire [7:0] base_wdata,
	input wire [15:0] table_base_q,
	input wire txn_req,
	input wire [3:0] txn_ep,
	input wire [1:0] txn_tok,
	input wire txn_ready_q,
	input wire ans_valid_q,
	input wire [1:0] ans_code_q,
	input wire ans_toggle_q,
	input wire [SIZE_W-1:0] ans_max_q,
	input wire mem_req_q,
	input wire mem_we_q,
	input wire [15:0] mem_addr_q,
	input wire mem_ack,
	input wire [7:0] mem_rdata,
	input wire cmpl_push_q,
	input wire [15:0] cmpl_addr_q
);
	logic [15:0] rec_q;
	logic [7:0] rb_q [0:7];
	wire [15:0] off = mem_addr_q - rec_q;
	wire [1:0] ty = rb_q[1][7:6];
	wire [2:0] sz = ty == 2'h3 ? rb_q[1][2:0] : {1'b0, rb_q[1][1:0]};
	wire [10:0] mx = sz == 3'h7 ? 11'h3FF : 11'h008 << sz;
	// Record start of the transaction in flight.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rec_q <= 16'h0000;
		end else if (ce && txn_req && txn_ready_q) begin
			rec_q <= table_base_q + {8'h00, txn_ep, 4'h0} + {12'h000, txn_tok == 2'h1, 3'h0};
		end
	end
	always @(posedge mclk) begin
		if (mem_ack && !mem_we_q && off < 16'h0008) begin
			rb_q[off[2:0]] <= mem_rdata;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	AST_BASE_LO: assert property (ce && base_lo_we |=> table_base_q[7:0] == $past(base_wdata))
		else $error("table base low byte not loaded");
	AST_REC_ADDR: assert property (mem_req_q |-> off < 16'h0008)
		else $error("access outside the endpoint record");
	AST_DISABLED: assert property (mem_ack && !mem_we_q && off == 16'h0001
		&& mem_rdata[7:6] == 2'h0 |=> (!mem_req_q && !ans_valid_q)[*3])
		else $error("disabled endpoint record touched");
	AST_STALL: assert property (ans_valid_q && ty == 2'h2 && rb_q[1][2]
		|-> ans_code_q == 2'h2)
		else $error("stalled endpoint not answered with stall");
	AST_NAK: assert property (ans_valid_q && ty == 2'h2 && !rb_q[1][2] && !rb_q[1][4]
		&& rb_q[0][1] |-> ans_code_q == 2'h1)
		else $error("refused buffer not answered with nak");
	AST_TOGGLE: assert property (ans_valid_q && ans_code_q == 2'h0
		|-> ans_toggle_q == (ty != 2'h3 && rb_q[0][0]))
		else $error("wrong data toggle");
	AST_MAX: assert property (ans_valid_q && ans_code_q == 2'h0 |-> ans_max_q == mx)
		else $error("wrong maximum payload");
	AST_PUSH: assert property (cmpl_push_q |-> !rb_q[1][3] && cmpl_addr_q == rec_q)
		else $error("bad completion push");
endmodule
bind ued_engine ued_engine_monitor #(.SIZE_W(SIZE_W)) ued_engine_monitor_inst (
	.mclk(mclk), .arst_n(arst_n), .ce(ce), .base_lo_we(base_lo_we),
	.base_wdata(base_wdata), .table_base_q(table_base_q), .txn_req(txn_req),
	.txn_ep(txn_ep), .txn_tok(txn_tok), .txn_ready_q(txn_ready_q), .ans_valid_q(ans_valid_q),
	.ans_code_q(ans_code_q), .ans_toggle_q(ans_toggle_q), .ans_max_q(ans_max_q),
	.mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_ack(mem_ack),
	.mem_rdata(mem_rdata), .cmpl_push_q(cmpl_push_q), .cmpl_addr_q(cmpl_addr_q));

/* test/tb.sv */
// Self-checking bench for the endpoint descriptor engine.
`timescale 1ns/1ps
module tb;
	logic mclk, arst_n, ce, lo_we, hi_we, req, dv, dok;
	logic [7:0] wd;
	logic [3:0] ep;
	logic [1:0] tok;
	logic [9:0] cnt;
	logic [15:0] base;
	logic [31:0] sd = 32'h000174D1;
	logic [31:0] v;
	logic [28:0] e;
	logic [28:0] expq [$];
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_push = 0;
	logic [15:0] push_a;
	wire [15:0] tbq, ma, ap, ca;
	wire [9:0] al;
	wire [7:0] md, mrd;
	wire [1:0] ac;
	wire rdy, av, at, mr, mw, mk, cp;
	ued_engine #(.SIZE_W(11)) ued_engine_inst (.mclk(mclk), .arst_n(arst_n), .ce(ce),
		.base_lo_we(lo_we), .base_hi_we(hi_we), .base_wdata(wd), .table_base_q(tbq),
		.txn_req(req), .txn_ep(ep), .txn_tok(tok), .txn_ready_q(rdy), .ans_valid_q(av),
		.ans_code_q(ac), .ans_toggle_q(at), .ans_ptr_q(ap), .ans_len_q(al), .ans_max_q(),
		.done_valid(dv), .done_ok(dok), .done_crc_err(~dok), .done_count(cnt),
		.mem_req_q(mr), .mem_we_q(mw), .mem_addr_q(ma), .mem_wdata_q(md), .mem_ack(mk),
		.mem_rdata(mrd), .cmpl_push_q(cp), .cmpl_addr_q(ca));
	ued_sram_model ued_sram_model_inst (.mclk(mclk), .mem_req_q(mr), .mem_we_q(mw),
		.mem_addr_q(ma), .mem_wdata_q(md), .mem_ack(mk), .mem_rdata(mrd));
	function automatic logic [31:0] rnd();
		sd = sd ^ (sd << 13);
		sd = sd ^ (sd >> 17);
		sd = sd ^ (sd << 5);
		return sd;
	endfunction
	task automatic tick();
		@(posedge mclk);
		#2;
	endtask
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
		n_compared++;
		if (s !== x) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic summarize();
		$display("mismatches %0d of %0d compared", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic wm(input logic [15:0] a, input logic [7:0] d);
		ued_sram_model_inst.mem[a] = d;
	endtask
	// Multipacket stays off; ping-pong is only ever set on bulk records.
	task automatic run(input logic [1:0] tk, input logic [7:0] ct, input logic [7:0] st,
		input logic [2:0] an, input logic ok, input logic [7:0] sm);
		logic [15:0] a;
		int np;
		logic [2:0] sc;
		logic [9:0] mx, ln;
		logic pe;
		v = rnd();
		a = base + {8'h00, v[3:0], 4'h0} + {12'h000, tk == 2'h1, 3'h0};
		wm(a, st);
		wm(a + 16'h1, ct);
		wm(a + 16'h2, v[23:16]);
		wm(a + 16'h3, 8'h00);
		wm(a + 16'h4, v[31:24]);
		wm(a + 16'h5, v[15:8]);
		wm(a + 16'h6, 8'h00);
		wm(a + 16'h7, 8'h00);
		sc = (ct[7:6] == 2'h3) ? ct[2:0] : {1'b0, ct[1:0]};
		mx = (sc == 3'h7) ? 10'h3FF : (10'h008 << sc);
		ln = ({2'h0, v[23:16]} > mx) ? mx : {2'h0, v[23:16]};
		pe = ct[7:6] != 2'h0 && an[2:1] == 2'h0 && ok && !ct[3];
		np = n_push;
		if (ct[7:6] != 2'h0) expq.push_back({ln, v[15:8], v[31:24], an});
		while (rdy !== 1'b1) tick();
		ep = v[3:0];
		tok = tk;
		req = 1'b1;
		tick();
		req = 1'b0;
		if (an[2:1] == 2'h0 && ct[7:6] != 2'h0) begin
			while (av !== 1'b1) tick();
			cnt = {7'h00, v[6:4]};
			dok = ok;
			dv = 1'b1;
			tick();
			dv = 1'b0;
		end
		repeat (2) tick();
		while (rdy !== 1'b1) tick();
		chk("status", 16'(ued_sram_model_inst.mem[a] & sm), 16'(sm));
		if (ct[7:6] == 2'h0) chk("untouched", 16'(ued_sram_model_inst.mem[a]), 16'(st));
		if (ct[7:6] != 2'h0 && tk != 2'h1 && an[2:1] == 2'h0 && ok) begin
			chk("count", 16'(ued_sram_model_inst.mem[a + 16'h2]), 16'(cnt));
		end
		chk("push", 16'(n_push - np), 16'(pe));
		if (n_push != np) chk("push addr", push_a, a);
	endtask
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			summarize();
		end
	end
	// Each answer pulse takes the oldest noted expectation.
	always @(posedge mclk) begin
		if (av === 1'b1) begin
			if (expq.size() == 0) begin
				chk("spare answer", 16'h0001, 16'h0000);
			end else begin
				e = expq.pop_front();
				chk("code", 16'(ac), 16'(e[2:1]));
				if (e[2:1] == 2'h0) chk("toggle", 16'(at), 16'(e[0]));
				chk("pointer", ap, e[18:3]);
				chk("length", 16'(al), 16'(e[28:19]));
			end
		end
	end
	// Completion pushes are counted for the scenario that caused them.
	always @(posedge mclk) begin
		if (cp === 1'b1) begin
			n_push++;
			push_a = ca;
		end
	end
	initial begin
		arst_n = 1'b0;
		{lo_we, hi_we, req, dv, dok} = 5'h00;
		ce = 1'b1;
		wd = 8'h00;
		ep = 4'h0;
		tok = 2'h0;
		cnt = 10'h000;
		base = 16'h0000;
		repeat (12) @(posedge mclk);
		#2;
		arst_n = 1'b1;
		v = rnd();
		wd = v[7:0];
		lo_we = 1'b1;
		tick();
		wd = v[15:8];
		lo_we = 1'b0;
		hi_we = 1'b1;
		tick();
		hi_we = 1'b0;
		base = v[15:0];
		chk("base", tbq, base);
		// A write strobe while the clock enable is low must leave the base alone.
		ce = 1'b0;
		wd = ~base[7:0];
		lo_we = 1'b1;
		tick();
		lo_we = 1'b0;
		ce = 1'b1;
		chk("frozen base", tbq, base);
		run(2'h1, 8'h00, 8'h00, 3'h0, 1'b1, 8'h00);
		run(2'h0, 8'h80, 8'h01, 3'h1, 1'b1, 8'h30);
		run(2'h1, 8'h84, 8'h00, 3'h4, 1'b1, 8'h80);
		run(2'h0, 8'h80, 8'h02, 3'h2, 1'b1, 8'h40);
		run(2'h1, 8'hC7, 8'h01, 3'h0, 1'b1, 8'h20);
		run(2'h2, 8'h41, 8'h00, 3'h0, 1'b1, 8'h10);
		run(2'h0, 8'hC0, 8'h00, 3'h0, 1'b0, 8'h80);
		run(2'h1, 8'h89, 8'h00, 3'h0, 1'b1, 8'h20);
		run(2'h0, 8'h90, 8'h08, 3'h0, 1'b1, 8'h34);
		run(2'h0, 8'h90, 8'h0C, 3'h2, 1'b1, 8'h40);
		run(2'h0, 8'hC0, 8'h02, 3'h6, 1'b1, 8'h40);
		tick();
		chk("queue", 16'(expq.size()), 16'h0000);
		summarize();
	end
endmodule
